// ===== src/lsd_pkg.sv
/*
 * Package for the led sink driver control logic: field positions of the
 * 49-bit serial word and of the control latch, reset values, mode codes.
 * Assumes nothing of its surroundings.
 */
package lsd_pkg;
    localparam int CHAIN_W = 49;
    localparam int CHAN_N = 48;
    localparam int GROUP_N = 16;
    localparam int SEL_BIT = 48;
    localparam int KEY_HI = 47;
    localparam int KEY_LO = 40;
    localparam logic [7:0] WRITE_KEY = 8'h96;
    localparam int CEIL_HI = 2;
    localparam int CEIL_LO = 0;
    localparam int RED_HI = 9;
    localparam int RED_LO = 3;
    localparam int GRN_HI = 16;
    localparam int GRN_LO = 10;
    localparam int BLU_HI = 23;
    localparam int BLU_LO = 17;
    localparam int SLS_HI = 25;
    localparam int SLS_LO = 24;
    localparam int OTS_HI = 28;
    localparam int OTS_LO = 26;
    localparam int STS_HI = 30;
    localparam int STS_LO = 29;
    localparam int LPS_HI = 32;
    localparam int LPS_LO = 31;
    localparam logic [2:0] CEIL_RST = 3'h0;
    localparam logic [1:0] LPS_RST = 2'h3;
    localparam logic [1:0] LPS_NEVER = 2'h0;
    localparam logic [1:0] LPS_CLK_WAKE = 2'h1;
    localparam logic [1:0] LPS_DATA_WAKE = 2'h2;
    localparam logic [1:0] LPS_ALWAYS = 2'h3;
    localparam logic [1:0] SLS_OPEN = 2'h1;
    localparam logic [1:0] SLS_SHORT = 2'h2;
endpackage : lsd_pkg

// ===== src/lsd_core.sv
/*
 * Control logic of a 48-channel constant-current led sink driver.
 * Assumes serial_clk, serial_in, latch_strobe and blank come from the
 * display controller asynchronously and are sampled by core_clk, which
 * must run well above four times the serial clock rate.
 */
//Function
//- separate 7-bit brightness per colour group, effective at once
//- blank low and not in low power: each sink follows its on/off latch bit
//- blank high: all sinks off, latch unchanged
//- reset clears the 48-bit on/off latch
//- low-power select 11b: always in low-power state
//- low-power select 00b: never in low-power state
//- select 01b or 10b: all-zero on/off commit enters low power
//- select 01b: any shift clock rise exits low power
//- select 10b: nonzero on/off commit exits low power
//- digital logic keeps shifting and latching in low power
//- shift clock rise shifts serial in to bit 0, top bit out
//- reset clears the 49-bit shift chain
//- strobe with bit 48 clear loads bits 47..0 into on/off latch
//- strobe with bit 48 set and key loads bits 32..3
//- ceiling code updates only on two equal keyed writes, resets 000b
//- latch bit 3k red, 3k+1 green, 3k+2 blue output k
//- brightness red 9..3, green 16..10, blue 23..17
//- status select 25..24, open 28..26, short 30..29
//- low-power select 32..31 resets 11b, bits 39..33 ignored
//- status select 01 open, 10 short, else nothing
//- on/off commit copies old chain then loads selected status
//- blank rise outside low power captures selected detector flags into holder
//- status loads once until new bits are shifted in
//- flags report 0 where on/off bit was 0 at the capturing blank rise
`timescale 1ns/1ps
module lsd_core
    import lsd_pkg::*;
#(
    parameter int N_CH = 48
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // serial link from the display controller
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic latch_strobe,
    input wire logic blank,
    output logic serial_out,
    // analog detector results
    input wire logic [N_CH-1:0] open_detect,
    input wire logic [N_CH-1:0] short_detect,
    // sink drive and analog settings
    output logic [lsd_pkg::GROUP_N-1:0] red_sink,
    output logic [lsd_pkg::GROUP_N-1:0] green_sink,
    output logic [lsd_pkg::GROUP_N-1:0] blue_sink,
    output logic [2:0] current_ceiling_code,
    output logic [6:0] red_brightness,
    output logic [6:0] green_brightness,
    output logic [6:0] blue_brightness,
    output logic [2:0] open_threshold_select,
    output logic [1:0] short_threshold_select,
    output logic low_power_state
);
    import lsd_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
        end else begin
            sync1 <= {blank, latch_strobe, serial_in, serial_clk};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    logic sclk_rise;
    logic lat_rise;
    logic blank_rise;
    logic blank_s;
    logic sin_s;
    // serial_in settles with the clock, so the stage before the edge is used
    assign sclk_rise = sync2[0] & ~sync3[0];
    assign lat_rise = sync2[2] & ~sync3[2];
    assign blank_rise = sync2[3] & ~sync3[3];
    assign blank_s = sync2[3];
    assign sin_s = sync3[1];

    // ------------------------------------------------------------
    // control latch fields
    // ------------------------------------------------------------
    logic [CHAIN_W-1:0] chain;
    logic [N_CH-1:0] on_latch;
    logic [1:0] status_load_select;
    logic [1:0] low_power_select;
    logic [2:0] ceiling_field;
    logic [N_CH-1:0] status_snapshot;
    logic status_spent;

    logic keyed_wr;
    logic onoff_wr;
    assign onoff_wr = lat_rise && !chain[SEL_BIT];
    assign keyed_wr = lat_rise && chain[SEL_BIT]
        && chain[KEY_HI:KEY_LO] == WRITE_KEY;

    // ------------------------------------------------------------
    // shift chain
    // ------------------------------------------------------------
    // sid load replaces lower bits after the old word was copied out
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            chain <= '0;
        end else if (sclk_rise) begin
            chain <= {chain[CHAIN_W-2:0], sin_s};
        end else if (onoff_wr && !status_spent
                     && (status_load_select == SLS_OPEN
                         || status_load_select == SLS_SHORT)) begin
            chain[N_CH-1:0] <= status_snapshot;
        end
    end
    assign serial_out = chain[SEL_BIT];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_spent <= 1'b0;
        end else if (sclk_rise) begin
            status_spent <= 1'b0;
        end else if (onoff_wr && (status_load_select == SLS_OPEN
                     || status_load_select == SLS_SHORT)) begin
            status_spent <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // on/off latch
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            on_latch <= '0;
        end else if (onoff_wr) begin
            on_latch <= chain[N_CH-1:0];
        end
    end

    // ------------------------------------------------------------
    // brightness and function latch
    // ------------------------------------------------------------
    // brightness and thresholds have no defined reset; zero chosen
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            red_brightness <= '0;
            green_brightness <= '0;
            blue_brightness <= '0;
            status_load_select <= '0;
            open_threshold_select <= '0;
            short_threshold_select <= '0;
            low_power_select <= LPS_RST;
        end else if (keyed_wr) begin
            red_brightness <= chain[RED_HI:RED_LO];
            green_brightness <= chain[GRN_HI:GRN_LO];
            blue_brightness <= chain[BLU_HI:BLU_LO];
            status_load_select <= chain[SLS_HI:SLS_LO];
            open_threshold_select <= chain[OTS_HI:OTS_LO];
            short_threshold_select <= chain[STS_HI:STS_LO];
            low_power_select <= chain[LPS_HI:LPS_LO];
        end
    end

    // ceiling needs the same value twice in a row to guard the current
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            current_ceiling_code <= CEIL_RST;
            ceiling_field <= CEIL_RST;
        end else if (keyed_wr) begin
            ceiling_field <= chain[CEIL_HI:CEIL_LO];
            if (chain[CEIL_HI:CEIL_LO] == ceiling_field) begin
                current_ceiling_code <= chain[CEIL_HI:CEIL_LO];
            end
        end
    end

    // ------------------------------------------------------------
    // low-power state
    // ------------------------------------------------------------
    logic lp_latched;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lp_latched <= 1'b0;
        end else begin
            case (low_power_select)
                LPS_CLK_WAKE: begin
                    if (sclk_rise) begin
                        lp_latched <= 1'b0;
                    end else if (onoff_wr && chain[N_CH-1:0] == '0) begin
                        lp_latched <= 1'b1;
                    end
                end
                LPS_DATA_WAKE: begin
                    if (onoff_wr) begin
                        lp_latched <= (chain[N_CH-1:0] == '0);
                    end
                end
                // a change of mode to 01b or 10b while asleep stays asleep; 00b wakes
                LPS_ALWAYS: lp_latched <= 1'b1;
                default: lp_latched <= 1'b0;
            endcase
        end
    end
    assign low_power_state = (low_power_select == LPS_ALWAYS)
        || (low_power_select != LPS_NEVER && lp_latched);

    // ------------------------------------------------------------
    // status holder
    // ------------------------------------------------------------
    // detectors are dead in low power; holder then keeps its content
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_snapshot <= '0;
        end else if (blank_rise && !low_power_state) begin
            if (status_load_select == SLS_OPEN) begin
                status_snapshot <= open_detect & on_latch;
            end else if (status_load_select == SLS_SHORT) begin
                status_snapshot <= short_detect & on_latch;
            end
        end
    end

    // ------------------------------------------------------------
    // sink gating
    // ------------------------------------------------------------
    // controller is trusted to keep blank high after wake-up
    genvar k;
    generate
        for (k = 0; k < GROUP_N; k++) begin : g_sink
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    red_sink[k] <= 1'b0;
                    green_sink[k] <= 1'b0;
                    blue_sink[k] <= 1'b0;
                end else begin
                    red_sink[k] <= on_latch[3*k] & ~blank_s
                        & ~low_power_state;
                    green_sink[k] <= on_latch[3*k+1] & ~blank_s
                        & ~low_power_state;
                    blue_sink[k] <= on_latch[3*k+2] & ~blank_s
                        & ~low_power_state;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_onoff_commit: assert property (@(posedge core_clk) disable iff (!arst_n)
        onoff_wr |=> on_latch == $past(chain[N_CH-1:0]))
        else $error("on/off latch missed commit");
    a_blank_forces_off: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        blank_s |=> red_sink == '0 && green_sink == '0)
        else $error("sink on while blanked");
    a_sink_follows: assert property (@(posedge core_clk) disable iff (!arst_n)
        !blank_s && !low_power_state |=> red_sink[0] == $past(on_latch[0]))
        else $error("red sink 0 not following latch");
    a_lp_always: assert property (@(posedge core_clk) disable iff (!arst_n)
        low_power_select == LPS_ALWAYS |-> low_power_state)
        else $error("not in low power with select 11");
    a_lp_never: assert property (@(posedge core_clk) disable iff (!arst_n)
        low_power_select == LPS_NEVER |-> !low_power_state)
        else $error("low power with select 00");
    a_clk_wakes: assert property (@(posedge core_clk) disable iff (!arst_n)
        low_power_select == LPS_CLK_WAKE && sclk_rise && !keyed_wr
        |=> !low_power_state)
        else $error("shift clock did not wake");
    a_zero_sleeps: assert property (@(posedge core_clk) disable iff (!arst_n)
        (low_power_select == LPS_DATA_WAKE) && onoff_wr
        && chain[N_CH-1:0] == '0 |=> low_power_state)
        else $error("zero commit did not sleep");
    a_shift_step: assert property (@(posedge core_clk) disable iff (!arst_n)
        sclk_rise |=> chain[CHAIN_W-1:1] == $past(chain[CHAIN_W-2:0]))
        else $error("chain did not shift");
    a_ceiling_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        keyed_wr && chain[CEIL_HI:CEIL_LO] != ceiling_field
        |=> $stable(current_ceiling_code))
        else $error("ceiling changed on single write");
    // masking is judged at capture; a later on/off commit leaves stale bits
    a_flags_masked: assert property (@(posedge core_clk) disable iff (!arst_n)
        blank_rise && !low_power_state && status_load_select == SLS_OPEN
        |=> status_snapshot == $past(open_detect & on_latch))
        else $error("open flags not captured masked");
    a_short_capture: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        blank_rise && !low_power_state && status_load_select == SLS_SHORT
        |=> status_snapshot == $past(short_detect & on_latch))
        else $error("short flags not captured masked");

    // ------------------------------------------------------------
    // field and state checks
    // ------------------------------------------------------------
    a_keyed_red: assert property (@(posedge core_clk) disable iff (!arst_n)
        keyed_wr |=> red_brightness == $past(chain[RED_HI:RED_LO]))
        else $error("red brightness not taken");
    a_keyed_green: assert property (@(posedge core_clk) disable iff (!arst_n)
        keyed_wr |=> green_brightness == $past(chain[GRN_HI:GRN_LO]))
        else $error("green brightness not taken");
    a_keyed_blue: assert property (@(posedge core_clk) disable iff (!arst_n)
        keyed_wr |=> blue_brightness == $past(chain[BLU_HI:BLU_LO]))
        else $error("blue brightness not taken");
    a_status_sel: assert property (@(posedge core_clk) disable iff (!arst_n)
        keyed_wr |=> status_load_select == $past(chain[SLS_HI:SLS_LO]))
        else $error("status select not taken");
    a_lps_field: assert property (@(posedge core_clk) disable iff (!arst_n)
        keyed_wr |=> low_power_select == $past(chain[LPS_HI:LPS_LO]))
        else $error("low-power select not taken");
    a_ceiling_twice: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        keyed_wr && chain[CEIL_HI:CEIL_LO] == ceiling_field
        |=> current_ceiling_code == $past(chain[CEIL_HI:CEIL_LO]))
        else $error("ceiling not taken on repeated write");
    a_data_wakes: assert property (@(posedge core_clk) disable iff (!arst_n)
        low_power_select == LPS_DATA_WAKE && onoff_wr
        && chain[N_CH-1:0] != '0 |=> !low_power_state)
        else $error("nonzero commit did not wake");
    a_clk_sleeps: assert property (@(posedge core_clk) disable iff (!arst_n)
        low_power_select == LPS_CLK_WAKE && onoff_wr
        && chain[N_CH-1:0] == '0 |=> low_power_state)
        else $error("zero commit did not sleep in clock-wake mode");
    a_status_load: assert property (@(posedge core_clk) disable iff (!arst_n)
        onoff_wr && !status_spent && (status_load_select == SLS_OPEN
        || status_load_select == SLS_SHORT)
        |=> chain[N_CH-1:0] == $past(status_snapshot))
        else $error("status not loaded into chain");
    a_no_reload: assert property (@(posedge core_clk) disable iff (!arst_n)
        onoff_wr && status_spent
        |=> chain[N_CH-1:0] == $past(chain[N_CH-1:0]))
        else $error("status loaded twice");
    a_green_follows: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        !blank_s && !low_power_state
        |=> green_sink[0] == $past(on_latch[1]))
        else $error("green sink 0 not following latch bit 1");
    a_lp_sinks_off: assert property (@(posedge core_clk)
        disable iff (!arst_n)
        low_power_state |=> red_sink == '0 && green_sink == '0
        && blue_sink == '0)
        else $error("sink on in low power");
endmodule : lsd_core

// ===== tb/lsd_ctrl_model.sv
/*
 * Display controller model: shifts 49-bit words msb first, strobes them
 * in and drives the blanking level.
 * Assumes a free-running core_clk; the serial clock is 160 ns, idle low.
 */
`timescale 1ns/1ps
module lsd_ctrl_model (
    // clock
    input wire logic core_clk,
    // serial link
    input wire logic serial_out,
    output logic serial_clk,
    output logic serial_in,
    output logic latch_strobe,
    output logic blank
);
    initial begin
        serial_clk = 1'b0;
        serial_in = 1'b0;
        latch_strobe = 1'b0;
        blank = 1'b1;
    end

    // sampled just before each rise, so got[i] is the old chain bit i
    task automatic shift_word(input logic [48:0] w, output logic [48:0] got);
        for (int i = 48; i >= 0; i--) begin
            @(negedge core_clk);
            serial_in = w[i];
            repeat (3) @(negedge core_clk);
            got[i] = serial_out;
            serial_clk = 1'b1;
            repeat (4) @(negedge core_clk);
            serial_clk = 1'b0;
        end
        // data line holds nothing useful between frames
        serial_in = ~serial_in;
    endtask : shift_word

    // strobe only with the serial clock low
    task automatic strobe();
        @(negedge core_clk);
        latch_strobe = 1'b1;
        repeat (4) @(negedge core_clk);
        latch_strobe = 1'b0;
        repeat (8) @(negedge core_clk);
    endtask : strobe

    task automatic tick();
        @(negedge core_clk);
        serial_clk = 1'b1;
        repeat (4) @(negedge core_clk);
        serial_clk = 1'b0;
        repeat (8) @(negedge core_clk);
    endtask : tick

    task automatic set_blank(input logic v);
        @(negedge core_clk);
        blank = v;
        repeat (8) @(negedge core_clk);
    endtask : set_blank
endmodule : lsd_ctrl_model

// ===== tb/lsd_core_test.sv
/*
 * Self-checking bench for lsd_core, driven through the controller model.
 * Assumes the field layout of lsd_pkg and a 50 MHz core clock.
 */
`timescale 1ns/1ps
module lsd_core_test;
    import lsd_pkg::*;
    localparam logic [47:0] ONW = 48'h8000_0000_0011;
    localparam logic [47:0] PO = 48'h1234_5678_9abc;
    localparam logic [47:0] PS = 48'hfedc_ba98_7654;
    logic core_clk, arst_n, serial_clk, serial_in, latch_strobe, blank;
    logic serial_out, low_power_state;
    logic [47:0] open_detect, short_detect;
    logic [15:0] red_sink, green_sink, blue_sink;
    logic [2:0] current_ceiling_code, open_threshold_select;
    logic [6:0] red_brightness, green_brightness, blue_brightness;
    logic [1:0] short_threshold_select;
    logic [48:0] got;
    int n_mismatch = 0;
    int checks = 0;

    lsd_core u_lsd_core (.core_clk(core_clk), .arst_n(arst_n),
        .serial_clk(serial_clk), .serial_in(serial_in),
        .latch_strobe(latch_strobe), .blank(blank), .serial_out(serial_out),
        .open_detect(open_detect), .short_detect(short_detect),
        .red_sink(red_sink), .green_sink(green_sink), .blue_sink(blue_sink),
        .current_ceiling_code(current_ceiling_code),
        .red_brightness(red_brightness), .green_brightness(green_brightness),
        .blue_brightness(blue_brightness),
        .open_threshold_select(open_threshold_select),
        .short_threshold_select(short_threshold_select),
        .low_power_state(low_power_state));
    lsd_ctrl_model u_lsd_ctrl_model (.core_clk(core_clk),
        .serial_out(serial_out), .serial_clk(serial_clk),
        .serial_in(serial_in), .latch_strobe(latch_strobe), .blank(blank));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [63:0] exp, act);
        checks++;
        if (act !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, act);
        end
    endtask : chk

    // ignored bits 39..33 carry a nonzero filler on purpose
    function automatic logic [48:0] ctl(input logic [1:0] lps, sls,
        input logic [2:0] ceil);
        return {1'b1, WRITE_KEY, 7'h55, lps, 2'h2, 3'h5, sls,
            7'h2a, 7'h13, 7'h61, ceil};
    endfunction : ctl

    task automatic wr(input logic [48:0] w);
        u_lsd_ctrl_model.shift_word(w, got);
        u_lsd_ctrl_model.strobe();
    endtask : wr

    task automatic chk_sinks(input logic [47:0] e);
        logic [15:0] r, g, b;
        for (int k = 0; k < 16; k++) begin
            r[k] = e[3*k];
            g[k] = e[3*k+1];
            b[k] = e[3*k+2];
        end
        chk("red_sink", r, red_sink);
        chk("green_sink", g, green_sink);
        chk("blue_sink", b, blue_sink);
    endtask : chk_sinks

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk("ceiling", 3'h0, current_ceiling_code);
        chk("low_power", 1'b1, low_power_state);
        chk("serial_out", 1'b0, serial_out);
    endtask : t_reset

    task automatic t_ctl();
        logic [48:0] w;
        u_lsd_ctrl_model.shift_word(ctl(2'h0, 2'h0, 3'h5), got);
        chk("chain", 49'h0, got);
        u_lsd_ctrl_model.strobe();
        chk("red", 7'h61, red_brightness);
        chk("green", 7'h13, green_brightness);
        chk("blue", 7'h2a, blue_brightness);
        chk("open_thr", 3'h5, open_threshold_select);
        chk("short_thr", 2'h2, short_threshold_select);
        chk("ceil_first", 3'h0, current_ceiling_code);
        chk("low_power", 1'b0, low_power_state);
        wr(ctl(2'h0, 2'h0, 3'h5));
        chk("ceil_twice", 3'h5, current_ceiling_code);
        wr(ctl(2'h0, 2'h0, 3'h3));
        chk("ceil_once", 3'h5, current_ceiling_code);
        w = ctl(2'h3, 2'h0, 3'h3);
        w[40] = 1'b1;
        wr(w);
        chk("bad_key", 1'b0, low_power_state);
        u_lsd_ctrl_model.set_blank(1'b0);
        chk_sinks(48'h0);
    endtask : t_ctl

    task automatic t_onoff();
        wr({1'b0, ONW});
        chk_sinks(ONW);
        u_lsd_ctrl_model.set_blank(1'b1);
        chk_sinks(48'h0);
        u_lsd_ctrl_model.set_blank(1'b0);
        chk_sinks(ONW);
    endtask : t_onoff

    task automatic t_lowpow();
        u_lsd_ctrl_model.set_blank(1'b1);
        wr(ctl(2'h1, 2'h0, 3'h3));
        wr(49'h0);
        chk("enter_clk", 1'b1, low_power_state);
        u_lsd_ctrl_model.tick();
        chk("exit_clk", 1'b0, low_power_state);
        wr(ctl(2'h2, 2'h0, 3'h3));
        wr(49'h0);
        chk("enter_data", 1'b1, low_power_state);
        wr({1'b0, ONW});
        chk("exit_data", 1'b0, low_power_state);
        wr(ctl(2'h0, 2'h0, 3'h3));
        wr(49'h0);
        chk("never", 1'b0, low_power_state);
        wr(ctl(2'h3, 2'h0, 3'h3));
        wr({1'b0, ONW});
        chk("always", 1'b1, low_power_state);
    endtask : t_lowpow

    // second blank rise refreshes the holder; a strobe without new
    // shifting must not reload it
    task automatic t_status(input logic [1:0] sel);
        logic [47:0] w, e;
        w = 48'h0f0f_3c3c_a5a5;
        e = (sel == 2'h1) ? (PO & w) : (sel == 2'h2) ? (PS & w) : w;
        @(negedge core_clk);
        open_detect = PO;
        short_detect = PS;
        wr(ctl(2'h0, sel, 3'h3));
        wr({1'b0, w});
        u_lsd_ctrl_model.set_blank(1'b0);
        u_lsd_ctrl_model.set_blank(1'b1);
        u_lsd_ctrl_model.set_blank(1'b0);
        wr({1'b0, w});
        chk_sinks(w);
        @(negedge core_clk);
        open_detect = ~PO;
        short_detect = ~PS;
        u_lsd_ctrl_model.set_blank(1'b1);
        u_lsd_ctrl_model.set_blank(1'b0);
        u_lsd_ctrl_model.strobe();
        chk_sinks(e);
        u_lsd_ctrl_model.shift_word(49'h0, got);
        chk("status", {1'b0, e}, got);
    endtask : t_status

    initial begin
        repeat (40000) @(posedge core_clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        arst_n = 1'b0;
        open_detect = 48'h0;
        short_detect = 48'h0;
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        t_reset();
        t_ctl();
        t_onoff();
        t_lowpow();
        for (int s = 0; s < 4; s++) begin
            t_status(s[1:0]);
        end
        // reset again in mid-run, with a nonzero on/off latch
        wr({1'b0, ONW});
        @(negedge core_clk);
        arst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        t_reset();
        chk_sinks(48'h0);
        print_verdict();
    end
endmodule : lsd_core_test
